// File: rtl/mic_irq_ctrl.sv
// Functional notes
// - low-voltage flag bit 7, enable bit 3
// - timer compare A flag bit 5, enable 1
// - timer compare P flag bit 4, enable 0
// - source event always sets its flag
// - flag causes jump only when enabled
// - global enable low blocks all interrupts
// - push next address, load vector, fetch
// - return pops saved address into counter
// - timer and low-voltage sources share group vectors
// - taking an interrupt clears global enable
// - requests during service still set flags
// - stack full blocks acknowledging requests
// - simultaneous requests served by fixed priority
// - any flag newly set by a source event wakes device
// - enabled member request sets group flag
// - service clears group flag and global enable
module mic_irq_ctrl
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [mic_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mic_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic std_timer_cmp_p_event,
   input wire logic std_timer_cmp_a_event,
   input wire logic periodic_timer0_cmp_p_event,
   input wire logic periodic_timer0_cmp_a_event,
   input wire logic periodic_timer1_cmp_p_event,
   input wire logic periodic_timer1_cmp_a_event,
   input wire logic low_voltage_event,
   input wire logic [mic_pkg::PC_W-1:0] next_pc,
   input wire logic stack_full,
   input wire logic return_from_interrupt,
   input wire logic sleep_request,
   output logic irq_take,
   output logic [mic_pkg::PC_W-1:0] saved_pc,
   output logic [mic_pkg::PC_W-1:0] vector_pc,
   output logic stack_pop,
   output logic asleep,
   output logic wake
);
   import mic_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic global_irq_enable;
      logic [NGRP-1:0] gen;
      logic [NSRC-1:0] me;
      logic asleep;
      logic wake;
      logic irq_take;
      logic [PC_W-1:0] saved_pc;
      logic [PC_W-1:0] vector_pc;
      logic stack_pop;
      logic awf;
      logic [ADDR_W-1:0] awaddr;
      logic wf;
      logic [7:0] wdata;
      logic wstb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mic_state_t;

   mic_state_t s;
   mic_state_t next_s;

   logic [NSRC-1:0] ev;
   logic [NSRC-1:0] mf;
   logic [NSRC-1:0] mf_new;
   logic [NSRC-1:0] mf_wen;
   logic [NSRC-1:0] mf_wval;
   logic [NGRP-1:0] gflag;
   logic [NGRP-1:0] g_set;
   logic [NGRP-1:0] g_wen;
   logic [NGRP-1:0] g_wval;
   logic [NGRP-1:0] g_req;
   logic [NGRP-1:0] g_grant;
   logic g_any;
   logic take;
   logic wr_go;
   logic wr_lvst;
   logic wr_ptim;
   logic wr_gctl;
   logic [PC_W-1:0] vec_sel;

   assign ev = {low_voltage_event, periodic_timer1_cmp_a_event, periodic_timer1_cmp_p_event,
                periodic_timer0_cmp_a_event, periodic_timer0_cmp_p_event,
                std_timer_cmp_a_event, std_timer_cmp_p_event};

   // ****************************************
   // write decode
   // ****************************************
   assign wr_go = s.awf & s.wf & ~s.bvalid;
   assign wr_lvst = wr_go & s.wstb & (s.awaddr == ADDR_LVST);
   assign wr_ptim = wr_go & s.wstb & (s.awaddr == ADDR_PTIM);
   assign wr_gctl = wr_go & s.wstb & (s.awaddr == ADDR_GCTL);

   // ****************************************
   // flags
   // ****************************************
   always_comb begin
      mf_wen = '0;
      mf_wval = '0;
      if (wr_lvst) begin
         mf_wen[SRC_LVD] = 1'b1;
         mf_wen[SRC_STM_A] = 1'b1;
         mf_wen[SRC_STM_P] = 1'b1;
         mf_wval[SRC_LVD] = s.wdata[LV_FLAG_BIT];
         mf_wval[SRC_STM_A] = s.wdata[STA_FLAG_BIT];
         mf_wval[SRC_STM_P] = s.wdata[STP_FLAG_BIT];
      end
      if (wr_ptim) begin
         mf_wen[SRC_PTM1_A:SRC_PTM0_P] = 4'hf;
         mf_wval[SRC_PTM1_A:SRC_PTM0_P] = s.wdata[PT_FLAG_LSB +: 4];
      end
   end

   mic_sticky_flags #(.WIDTH(NSRC)) u_member_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(ev),
      .wr_en(mf_wen),
      .wr_val(mf_wval),
      .q(mf)
   );

   assign mf_new = ev & ~mf;

   always_comb begin
      for (int k = 0; k < NGRP; k++) begin
         g_set[k] = |(ev & s.me & GRP_MASK[k]);
      end
   end

   assign g_wen = (wr_gctl ? {NGRP{1'b1}} : '0) | (take ? g_grant : '0);
   assign g_wval = (wr_gctl ? s.wdata[GCTL_GFLAG_LSB +: NGRP] : '0) & ~(take ? g_grant : '0);

   mic_sticky_flags #(.WIDTH(NGRP)) u_group_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(g_set),
      .wr_en(g_wen),
      .wr_val(g_wval),
      .q(gflag)
   );

   // ****************************************
   // arbitration
   // ****************************************
   // only enabled groups request
   assign g_req = gflag & s.gen;

   mic_prio_pick #(.WIDTH(NGRP)) u_pick (
      .req(g_req),
      .grant(g_grant),
      .any(g_any)
   );

   // global gate and stack full gate
   assign take = s.global_irq_enable & ~stack_full & g_any;

   always_comb begin
      vec_sel = '0;
      for (int k = 0; k < NGRP; k++) begin
         if (g_grant[k]) begin
            vec_sel = GRP_VEC[k];
         end
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [7:0] rd;
      logic hit;
      rd = REG_RESET;
      hit = 1'b1;
      next_s = s;
      next_s.wake = 1'b0;
      next_s.irq_take = 1'b0;
      next_s.stack_pop = return_from_interrupt;
      if (s_axi_awvalid && s.awready) begin
         next_s.awf = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wf = 1'b1;
         next_s.wdata = s_axi_wdata[7:0];
         next_s.wstb = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_s.awf = 1'b0;
         next_s.wf = 1'b0;
         next_s.bvalid = 1'b1;
         case (s.awaddr)
            ADDR_LVST, ADDR_PTIM, ADDR_GCTL, ADDR_STAT: next_s.bresp = RESP_OKAY;
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end
      if (wr_lvst) begin
         next_s.me[SRC_LVD] = s.wdata[LV_EN_BIT];
         next_s.me[SRC_STM_A] = s.wdata[STA_EN_BIT];
         next_s.me[SRC_STM_P] = s.wdata[STP_EN_BIT];
      end
      if (wr_ptim) begin
         next_s.me[SRC_PTM1_A:SRC_PTM0_P] = s.wdata[PT_EN_LSB +: 4];
      end
      if (wr_gctl) begin
         next_s.global_irq_enable = s.wdata[GCTL_GIE_BIT];
         next_s.gen = s.wdata[GCTL_GEN_LSB +: NGRP];
      end
      // push address and load vector, clear global enable
      if (take) begin
         next_s.global_irq_enable = 1'b0;
         next_s.irq_take = 1'b1;
         next_s.saved_pc = next_pc;
         next_s.vector_pc = vec_sel;
      end
      if (sleep_request) begin
         next_s.asleep = 1'b1;
      end
      if (s.asleep && ((|mf_new) || (|(g_set & ~gflag)))) begin
         next_s.asleep = 1'b0;
         next_s.wake = 1'b1;
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         case (s_axi_araddr)
            ADDR_LVST: begin
               rd[LV_FLAG_BIT] = mf[SRC_LVD];
               rd[STA_FLAG_BIT] = mf[SRC_STM_A];
               rd[STP_FLAG_BIT] = mf[SRC_STM_P];
               rd[LV_EN_BIT] = s.me[SRC_LVD];
               rd[STA_EN_BIT] = s.me[SRC_STM_A];
               rd[STP_EN_BIT] = s.me[SRC_STM_P];
            end
            ADDR_PTIM: begin
               rd[PT_FLAG_LSB +: 4] = mf[SRC_PTM1_A:SRC_PTM0_P];
               rd[PT_EN_LSB +: 4] = s.me[SRC_PTM1_A:SRC_PTM0_P];
            end
            ADDR_GCTL: begin
               rd[GCTL_GIE_BIT] = s.global_irq_enable;
               rd[GCTL_GFLAG_LSB +: NGRP] = gflag;
               rd[GCTL_GEN_LSB +: NGRP] = s.gen;
            end
            ADDR_STAT: begin
               rd[STAT_FULL_BIT] = stack_full;
               rd[STAT_SLEEP_BIT] = s.asleep;
            end
            default: hit = 1'b0;
         endcase
         next_s.rvalid = 1'b1;
         next_s.rdata = {24'h000000, rd};
         next_s.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end
      next_s.awready = ~next_s.awf & ~next_s.bvalid;
      next_s.wready = ~next_s.wf & ~next_s.bvalid;
      next_s.arready = ~next_s.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign irq_take = s.irq_take;
   assign saved_pc = s.saved_pc;
   assign vector_pc = s.vector_pc;
   assign stack_pop = s.stack_pop;
   assign asleep = s.asleep;
   assign wake = s.wake;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_take;
      take;
   endsequence

   sequence seq_entry;
      irq_take ##1 !irq_take;
   endsequence

   AST_ENTRY_ONE_PULSE: assert property (seq_take |=> seq_entry)
      else $error("entry pulse not single");
   AST_TAKE_NEEDS_GIE: assert property (irq_take |-> $past(s.global_irq_enable))
      else $error("taken with global enable low");
   AST_GIE_CLEARED: assert property (irq_take |-> !s.global_irq_enable)
      else $error("global enable not cleared on entry");
   AST_STACK_FULL_BLOCKS: assert property (irq_take |-> !$past(stack_full))
      else $error("taken while stack full");
   AST_ENABLED_ONLY: assert property (irq_take |-> $past(|(gflag & s.gen)))
      else $error("taken without enabled request");
   AST_PUSH_PC: assert property (take |=> saved_pc == $past(next_pc))
      else $error("pushed address wrong");
   AST_FLAG_SETS: assert property (std_timer_cmp_a_event |=> mf[SRC_STM_A])
      else $error("event flag not held");
   AST_RETURN_POP: assert property (return_from_interrupt |=> stack_pop)
      else $error("no pop after return");
   AST_GROUP_CLEARED: assert property (take && !(|g_set) |=> !(|(gflag & $past(g_grant))))
      else $error("group flag kept after service");
   AST_WAKE: assert property (s.asleep && (|mf_new) |=> wake && !asleep)
      else $error("no wake on new flag");
endmodule

// File: rtl/mic_pkg.sv
package mic_pkg;
   // ****************************************
   // widths and counts
   // ****************************************
   localparam int PC_W = 13;
   localparam int ADDR_W = 8;
   localparam int NSRC = 7;
   localparam int NGRP = 3;

   // ****************************************
   // register offsets and reset value
   // ****************************************
   localparam logic [ADDR_W-1:0] ADDR_LVST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_PTIM = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_GCTL = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ****************************************
   // source indices
   // ****************************************
   localparam int SRC_STM_P = 0;
   localparam int SRC_STM_A = 1;
   localparam int SRC_PTM0_P = 2;
   localparam int SRC_PTM0_A = 3;
   localparam int SRC_PTM1_P = 4;
   localparam int SRC_PTM1_A = 5;
   localparam int SRC_LVD = 6;

   // ****************************************
   // field positions
   // ****************************************
   localparam int LV_FLAG_BIT = 7;
   localparam int LV_EN_BIT = 3;
   localparam int STA_FLAG_BIT = 5;
   localparam int STA_EN_BIT = 1;
   localparam int STP_FLAG_BIT = 4;
   localparam int STP_EN_BIT = 0;
   localparam int PT_FLAG_LSB = 4;
   localparam int PT_EN_LSB = 0;
   localparam int GCTL_GIE_BIT = 0;
   localparam int GCTL_GFLAG_LSB = 1;
   localparam int GCTL_GEN_LSB = 4;
   localparam int STAT_FULL_BIT = 0;
   localparam int STAT_SLEEP_BIT = 1;

   // ****************************************
   // groups, vectors, responses
   // ****************************************
   localparam logic [NGRP-1:0][NSRC-1:0] GRP_MASK = {7'h70, 7'h0c, 7'h03};
   localparam logic [NGRP-1:0][PC_W-1:0] GRP_VEC = {13'h001c, 13'h0018, 13'h0014};
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/mic_sticky_flags.sv
module mic_sticky_flags #(
   parameter int WIDTH = 7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] wr_en,
   input wire logic [WIDTH-1:0] wr_val,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } mic_flag_state_t;

   mic_flag_state_t s;
   mic_flag_state_t next_s;

   // set wins over a clear in the same cycle
   always_comb begin
      next_s.flags = set | ((wr_en & wr_val) | (~wr_en & s.flags));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.flags;
endmodule

// File: rtl/mic_prio_pick.sv
module mic_prio_pick #(
   parameter int WIDTH = 3
) (
   input wire logic [WIDTH-1:0] req,
   output logic [WIDTH-1:0] grant,
   output logic any
);
   // lowest index has the highest priority
   always_comb begin
      grant = '0;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (req[i]) begin
            grant = '0;
            grant[i] = 1'b1;
         end
      end
      any = |req;
   end
endmodule

// File: test/mic_core_model.sv
module mic_core_model #(
   parameter int DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_take,
   input wire logic [mic_pkg::PC_W-1:0] saved_pc,
   input wire logic [mic_pkg::PC_W-1:0] vector_pc,
   input wire logic stack_pop,
   input wire logic ret_cmd,
   output logic [mic_pkg::PC_W-1:0] next_pc,
   output logic stack_full,
   output logic return_from_interrupt,
   output logic [mic_pkg::PC_W-1:0] pc
);
   timeunit 1ns;
   timeprecision 1ps;
   import mic_pkg::*;
   logic [PC_W-1:0] stack [DEPTH];
   int depth;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc <= '0;
         depth <= 0;
         return_from_interrupt <= 1'b0;
      end else begin
         return_from_interrupt <= ret_cmd;
         pc <= pc + 1'b1;
         if (irq_take && depth < DEPTH) begin
            stack[depth] <= saved_pc;
            depth <= depth + 1;
            pc <= vector_pc;
         end else if (stack_pop && depth > 0) begin
            pc <= stack[depth-1];
            depth <= depth - 1;
         end
      end
   end

   assign next_pc = pc + 1'b1;
   assign stack_full = (depth == DEPTH);
endmodule

// File: test/mic_irq_ctrl_test.sv
module mic_irq_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import mic_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0, rnd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [6:0] ev = '0;
   logic sleep_req = 1'b0, ret_cmd = 1'b0;
   logic [PC_W-1:0] next_pc, saved_pc, vector_pc, pc, prev_pc;
   logic stack_full, ret_pulse, irq_take, stack_pop, asleep, wake;
   logic [39:0] r_q[$], b_q[$], i_q[$];
   logic [PC_W-1:0] ret_q[$];
   int bad_count = 0, comparisons = 0, seed = 88, n;

   always #2.5 aclk = ~aclk;

   mic_irq_ctrl mic_irq_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .std_timer_cmp_p_event(ev[SRC_STM_P]), .std_timer_cmp_a_event(ev[SRC_STM_A]),
      .periodic_timer0_cmp_p_event(ev[SRC_PTM0_P]), .periodic_timer0_cmp_a_event(ev[SRC_PTM0_A]),
      .periodic_timer1_cmp_p_event(ev[SRC_PTM1_P]), .periodic_timer1_cmp_a_event(ev[SRC_PTM1_A]),
      .low_voltage_event(ev[SRC_LVD]), .next_pc(next_pc), .stack_full(stack_full),
      .return_from_interrupt(ret_pulse), .sleep_request(sleep_req), .irq_take(irq_take),
      .saved_pc(saved_pc), .vector_pc(vector_pc), .stack_pop(stack_pop), .asleep(asleep), .wake(wake));

   mic_core_model #(.DEPTH(2)) mic_core_model_inst (.aclk(aclk), .aresetn(aresetn),
      .irq_take(irq_take), .saved_pc(saved_pc), .vector_pc(vector_pc), .stack_pop(stack_pop),
      .ret_cmd(ret_cmd), .next_pc(next_pc), .stack_full(stack_full),
      .return_from_interrupt(ret_pulse), .pc(pc));

   // ****************************************
   // comparison and closing
   // ****************************************
   task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   function automatic logic [39:0] pop(ref logic [39:0] q[$]);
      return q.size() ? q.pop_front() : 'x;
   endfunction

   task automatic print_verdict();
      chk("pending takes", 40'h0, 40'(i_q.size()));
      if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic tick(inout int k);
      @(posedge aclk);
      k++;
      if (k > 200) begin
         chk("wait", 40'd200, 40'(k));
         print_verdict();
      end
   endtask

   always @(posedge aclk) begin
      if (aresetn) begin
         if (rvalid === 1'b1 && rready) chk("read", pop(r_q), {6'h0, rresp, rdata});
         if (bvalid === 1'b1 && bready) chk("bresp", pop(b_q), {38'h0, bresp});
         if (irq_take === 1'b1) begin
            chk("vector", pop(i_q), {27'h0, vector_pc});
            chk("saved", {27'h0, prev_pc}, {27'h0, saved_pc});
            ret_q.push_back(prev_pc);
         end
      end
      prev_pc = next_pc;
   end

   // ****************************************
   // bus and stimulus tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      int k;
      logic aw_d, w_d;
      k = 0;
      aw_d = 1'b0;
      w_d = 1'b0;
      b_q.push_back({38'h0, r});
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         tick(k);
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do tick(k); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      int k;
      logic ar_d, r_d;
      k = 0;
      ar_d = 1'b0;
      r_d = 1'b0;
      r_q.push_back({6'h0, r, 24'h0, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_d) begin
         tick(k);
         if (ar_d && rvalid === 1'b1) begin
            r_d = 1'b1;
            rready <= 1'b0;
         end
         if (!ar_d && arready === 1'b1) begin
            ar_d = 1'b1;
            arvalid <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   task automatic pulse(input logic [6:0] m);
      ev <= m;
      @(posedge aclk);
      ev <= '0;
      @(posedge aclk);
   endtask

   task automatic sleep_wake(input logic [6:0] m);
      sleep_req <= 1'b1;
      @(posedge aclk);
      sleep_req <= 1'b0;
      rd(ADDR_STAT, 8'h02);
      ev <= m;
      n = 0;
      do tick(n); while (wake !== 1'b1);
      ev <= '0;
      rd(ADDR_STAT, 8'h00);
   endtask

   task automatic ret();
      ret_cmd <= 1'b1;
      @(posedge aclk);
      ret_cmd <= 1'b0;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) rd(8'(i * 4), REG_RESET);
      rd(8'h10, 8'h00, RESP_SLVERR);
      wr(8'h10, 8'hff, RESP_SLVERR);
      wr(ADDR_LVST, 8'hff);
      rd(ADDR_LVST, 8'hbb);
      for (int i = 0; i < 4; i++) begin
         rnd = 8'($random(seed));
         wr(ADDR_PTIM, rnd);
         rd(ADDR_PTIM, rnd);
      end
      wstrb <= 4'h0;
      wr(ADDR_PTIM, ~rnd);
      wstrb <= 4'h1;
      rd(ADDR_PTIM, rnd);
      wr(ADDR_LVST, 8'h00);
      wr(ADDR_PTIM, 8'h00);
      pulse(7'h7f);
      rd(ADDR_LVST, 8'hb0);
      rd(ADDR_PTIM, 8'hf0);
      rd(ADDR_GCTL, 8'h00);
      wr(ADDR_LVST, 8'h00);
      wr(ADDR_PTIM, 8'h00);
      sleep_wake(7'h40);
      sleep_req <= 1'b1;
      @(posedge aclk);
      sleep_req <= 1'b0;
      pulse(7'h40);
      repeat (5) @(posedge aclk);
      rd(ADDR_STAT, 8'h02);
      ev <= 7'h02;
      n = 0;
      do tick(n); while (wake !== 1'b1);
      ev <= '0;
      rd(ADDR_STAT, 8'h00);
      wr(ADDR_LVST, 8'h02);
      wr(ADDR_GCTL, 8'h10);
      pulse(7'h02);
      rd(ADDR_GCTL, 8'h12);
      i_q.push_back(40'h14);
      wr(ADDR_GCTL, 8'h13);
      repeat (3) @(posedge aclk);
      rd(ADDR_GCTL, 8'h10);
      pulse(7'h02);
      rd(ADDR_GCTL, 8'h12);
      rd(ADDR_LVST, 8'h22);
      ret();
      n = 0;
      do tick(n); while (stack_pop !== 1'b1);
      @(posedge aclk);
      chk("resume", {27'h0, ret_q.pop_back()}, {27'h0, pc});
      wr(ADDR_LVST, 8'h00);
      wr(ADDR_GCTL, 8'h70);
      i_q.push_back(40'h18);
      wr(ADDR_GCTL, 8'h7d);
      repeat (3) @(posedge aclk);
      rd(ADDR_GCTL, 8'h78);
      i_q.push_back(40'h1c);
      wr(ADDR_GCTL, 8'h79);
      repeat (3) @(posedge aclk);
      rd(ADDR_STAT, 8'h01);
      wr(ADDR_GCTL, 8'h73);
      repeat (5) @(posedge aclk);
      rd(ADDR_GCTL, 8'h73);
      i_q.push_back(40'h14);
      ret();
      repeat (8) @(posedge aclk);
      rd(ADDR_GCTL, 8'h70);
      print_verdict();
   end
endmodule
